// ==== src/rtcc_pkg.sv ====
// Constants, field layout and carriers for the counter control block.
// Assumes a 32-bit APB master and one 250 MHz reference clock.
package rtcc_pkg;

	// Register byte offsets
	localparam logic [11:0] RTCC_CTRL_OFF   = 12'h000;
	localparam logic [11:0] RTCC_STATUS_OFF = 12'h004;

	// Control register field positions
	localparam int RTCC_SOFT_RESET_REQUEST_BIT   = 0;
	localparam int RTCC_ENABLE_BIT  = 1;
	localparam int RTCC_MODE_LSB    = 2;
	localparam int RTCC_HOURFMT_BIT = 6;
	localparam int RTCC_MCLR_BIT    = 7;
	localparam int RTCC_PRESC_LSB   = 8;

	// Status register field positions
	localparam int RTCC_PEND_BIT    = 0;
	localparam int RTCC_ACTIVE_BIT  = 1;

	// Values after reset
	localparam logic [15:0] RTCC_CTRL_RESET = 16'h0000;
	localparam logic [31:0] RTCC_RDATA_IDLE = 32'h0000_0000;

	// Largest prescaler code in use; codes above it are reserved
	localparam logic [3:0]  RTCC_PRESC_MAX  = 4'hA;
	localparam logic [9:0]  RTCC_DIV_ONES   = 10'h3FF;

	// Operating modes
	typedef enum logic [1:0] {
		RTCC_MODE_CNT32 = 2'b00,
		RTCC_MODE_CNT16 = 2'b01,
		RTCC_MODE_CLOCK = 2'b10,
		RTCC_MODE_RSVD  = 2'b11
	} rtcc_mode_e;

	// Software view of the control register
	typedef struct packed {
		logic [3:0] prescaler;
		logic       clear_on_match;
		logic       hour_format;
		rtcc_mode_e mode;
		logic       enable;
		logic       soft_reset_request;
	} rtcc_ctrl_s;

	// Controls handed to the counter logic
	typedef struct packed {
		logic       running;
		logic       counter_tick;
		logic       counter_clear;
		logic       soft_reset;
		rtcc_mode_e mode;
		logic       hour_12h;
	} rtcc_cnt_s;

endpackage

// ==== src/rtcc_sync_ctl.sv ====
// Counter-side half of the enable and reset handshake.
// Assumes src_edge marks one synchronised edge of the source clock.
`timescale 1ns/1ps
module rtcc_sync_ctl (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rst,
	// Source clock edge strobe
	input  wire logic src_edge,
	// Request from the bus side
	input  wire logic req_tog,
	input  wire logic req_enable,
	input  wire logic req_reset,
	// Acknowledge and counter-side state
	output logic      ack_tog,
	output logic      active,
	output logic      reset_pulse
);

	// Apply a pending request on a source edge, then acknowledge
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ack_tog     <= 1'b0;
			active      <= 1'b0;
			reset_pulse <= 1'b0;
		end else begin
			reset_pulse <= 1'b0;
			if (src_edge && (req_tog != ack_tog)) begin
				ack_tog     <= req_tog;
				active      <= req_enable & ~req_reset;
				reset_pulse <= req_reset;
			end
		end
	end

endmodule

// ==== src/rtcc_ctrl.sv ====
// Control register of the real-time counter, reached over APB.
// Assumes the source clock pin is slower than half of ref_clk and that
// compare_match comes from counter logic on ref_clk.
// Crossing notes:
// - Bus side flips req_tog, holds enable and reset request levels
// - Counter side applies them on the next source edge, echoes the toggle
// - Pending while the two toggles differ, or while a round is queued
// - Request during a busy round: queued, sent as one more round
// - Counter side therefore ends on the latest written values, except an enable written while a soft reset is pending: it stays stopped
// Lock notes:
// - Mode, prescaler, clear-on-match, hour format: open only when idle
// - Idle means enable off, counter side stopped, nothing pending
// - Locked writes dropped silently, no bus error
// - Enable and soft reset never locked
// Status word:
// - Own offset, bit 0 pending, bit 1 counter side running
// Prescaler notes:
// - Free 10-bit count of source edges while running
// - Tick when the low code bits are all ones
// - Reserved codes divide as the largest code
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
module rtcc_ctrl (
	// Clock and reset
	input  wire logic                ref_clk,
	input  wire logic                rst,
	// APB slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	input  wire logic [3:0]          pstrb,
	output logic                     pready,
	output logic [31:0]              prdata,
	output logic                     pslverr,
	// Counter source clock pin
	input  wire logic                rtc_source_clock,
	// Compare or alarm 0 match from the counter
	input  wire logic                compare_match,
	// Controls to the counter
	output rtcc_pkg::rtcc_cnt_s      cnt_ctl
);

	// Register image after reset, unpacked field by field
	localparam logic [15:0] RST_IMG = rtcc_pkg::RTCC_CTRL_RESET;
	localparam rtcc_pkg::rtcc_ctrl_s CTRL_INIT = '{
		prescaler:          RST_IMG[rtcc_pkg::RTCC_PRESC_LSB +: 4],
		clear_on_match:     RST_IMG[rtcc_pkg::RTCC_MCLR_BIT],
		hour_format:        RST_IMG[rtcc_pkg::RTCC_HOURFMT_BIT],
		mode:               rtcc_pkg::rtcc_mode_e'(
			RST_IMG[rtcc_pkg::RTCC_MODE_LSB +: 2]),
		enable:             RST_IMG[rtcc_pkg::RTCC_ENABLE_BIT],
		soft_reset_request: RST_IMG[rtcc_pkg::RTCC_SOFT_RESET_REQUEST_BIT]
	};

	// Control register and handshake state
	rtcc_pkg::rtcc_ctrl_s ctrl;
	logic                 req_tog;
	logic                 again;
	logic                 ack_tog;
	logic                 active;
	logic                 reset_pulse;

	// Source clock synchroniser and edge detect
	logic                 src_meta;
	logic                 src_sync;
	logic                 src_prev;
	logic                 src_edge;

	// Prescaler
	logic [9:0]           div_cnt;
	logic [9:0]           div_mask;
	logic [3:0]           presc_code;

	// Bus decode
	logic                 setup;
	logic                 wr_access;
	logic                 hit_ctrl;
	logic                 hit_status;
	logic                 lane0;
	logic                 lane1;
	logic                 wr_ctrl;
	logic                 soft_reset_request_write;
	logic                 enable_change;
	logic                 sync_start;
	logic                 busy;
	logic                 sync_pending;
	logic                 unlocked;
	logic                 match_clear;
	logic [31:0]          next_rdata;

	// Address decode and phases of a transfer
	assign setup      = psel & ~penable;
	assign wr_access  = psel & penable & pready & pwrite;
	assign hit_ctrl   = (paddr == rtcc_pkg::RTCC_CTRL_OFF);
	assign hit_status = (paddr == rtcc_pkg::RTCC_STATUS_OFF);
	assign lane0      = pstrb[0];
	assign lane1      = pstrb[1];
	assign wr_ctrl    = wr_access & hit_ctrl;

	// Write classification
	assign soft_reset_request_write   = wr_ctrl & lane0 &
		pwdata[rtcc_pkg::RTCC_SOFT_RESET_REQUEST_BIT];
	assign enable_change = wr_ctrl & lane0 &
		(pwdata[rtcc_pkg::RTCC_ENABLE_BIT] != ctrl.enable);
	// Only enable and soft reset start a synchronisation
	assign sync_start = soft_reset_request_write | enable_change;

	// Handshake status
	assign busy         = (req_tog != ack_tog);
	assign sync_pending = busy | again;

	// Protected fields wait until disable has fully completed
	assign unlocked = ~ctrl.enable & ~active & ~sync_pending;

	// Source clock pin: two flops, then edge detect on the second
	// Edge detect resets low, matching the idle pin, so no false edge
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			src_meta <= 1'b0;
			src_sync <= 1'b0;
			src_prev <= 1'b0;
		end else begin
			src_meta <= rtc_source_clock;
			src_sync <= src_meta;
			src_prev <= src_sync;
		end
	end

	assign src_edge = src_sync & ~src_prev;

	// Control register: bus writes, soft reset and its completion
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl <= CTRL_INIT;
		end else if (soft_reset_request_write) begin
			// Reset wins; other fields of this write are dropped
			ctrl                    <= CTRL_INIT;
			ctrl.soft_reset_request <= 1'b1;
		end else if (wr_ctrl) begin
			// Finished reset request must not ride on this write's round
			if (!sync_pending) begin
				ctrl.soft_reset_request <= 1'b0;
			end
			if (lane0) begin
				// Enable is never locked and reads back at once
				ctrl.enable <= pwdata[rtcc_pkg::RTCC_ENABLE_BIT];
				if (unlocked) begin
					ctrl.mode <= rtcc_pkg::rtcc_mode_e'(
						pwdata[rtcc_pkg::RTCC_MODE_LSB +: 2]);
					ctrl.hour_format <=
						pwdata[rtcc_pkg::RTCC_HOURFMT_BIT];
					ctrl.clear_on_match <=
						pwdata[rtcc_pkg::RTCC_MCLR_BIT];
				end
			end
			if (lane1 && unlocked) begin
				ctrl.prescaler <=
					pwdata[rtcc_pkg::RTCC_PRESC_LSB +: 4];
			end
		end else if (!sync_pending) begin
			// Stored bit lags pending by one cycle; read view masks it
			ctrl.soft_reset_request <= 1'b0;
		end
	end

	// Bus side of the handshake; a request during a busy one is queued
	// Queueing keeps req_tog stable while the counter side samples
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			req_tog <= 1'b0;
			again   <= 1'b0;
		end else if (sync_start) begin
			if (busy || again) begin
				again <= 1'b1;
			end else begin
				req_tog <= ~req_tog;
			end
		end else if (!busy && again) begin
			req_tog <= ~req_tog;
			again   <= 1'b0;
		end
	end

	// Counter-side half of the crossing
	rtcc_sync_ctl u_sync (
		.ref_clk     (ref_clk),
		.rst         (rst),
		.src_edge    (src_edge),
		.req_tog     (req_tog),
		.req_enable  (ctrl.enable),
		.req_reset   (ctrl.soft_reset_request),
		.ack_tog     (ack_tog),
		.active      (active),
		.reset_pulse (reset_pulse)
	);

	// Reserved prescaler codes behave as the largest division
	assign presc_code = (ctrl.prescaler > rtcc_pkg::RTCC_PRESC_MAX) ?
		rtcc_pkg::RTCC_PRESC_MAX : ctrl.prescaler;
	assign div_mask   = ~(rtcc_pkg::RTCC_DIV_ONES << presc_code);

	// Prescaler counts source edges while the counter runs
	// Cleared when stopped, so the first tick after enable is a full one
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			div_cnt <= 10'h000;
		end else if (!active || reset_pulse) begin
			div_cnt <= 10'h000;
		end else if (src_edge) begin
			div_cnt <= div_cnt + 10'h001;
		end
	end

	// Clear on match only in 32-bit counter and clock modes
	always_comb begin
		match_clear = 1'b0;
		case (ctrl.mode)
			rtcc_pkg::RTCC_MODE_CNT32: begin
				match_clear = ctrl.clear_on_match & compare_match;
			end
			rtcc_pkg::RTCC_MODE_CLOCK: begin
				match_clear = ctrl.clear_on_match & compare_match;
			end
			default: begin
				match_clear = 1'b0;
			end
		endcase
	end

	// Registered controls to the counter
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt_ctl <= '0;
		end else begin
			cnt_ctl.running       <= active;
			cnt_ctl.counter_tick  <= active & src_edge &
				((div_cnt & div_mask) == div_mask);
			cnt_ctl.counter_clear <= reset_pulse |
				(active & match_clear);
			cnt_ctl.soft_reset    <= reset_pulse;
			cnt_ctl.mode          <= ctrl.mode;
			cnt_ctl.hour_12h      <= (ctrl.mode == rtcc_pkg::RTCC_MODE_CLOCK) &
				ctrl.hour_format;
		end
	end

	// Read data for the current address
	always_comb begin
		next_rdata = rtcc_pkg::RTCC_RDATA_IDLE;
		if (hit_ctrl) begin
			// Reset bit and pending flag read back clear together
			next_rdata[rtcc_pkg::RTCC_SOFT_RESET_REQUEST_BIT] =
				ctrl.soft_reset_request & sync_pending;
			next_rdata[rtcc_pkg::RTCC_ENABLE_BIT] = ctrl.enable;
			next_rdata[rtcc_pkg::RTCC_MODE_LSB +: 2] = ctrl.mode;
			next_rdata[rtcc_pkg::RTCC_HOURFMT_BIT] = ctrl.hour_format;
			next_rdata[rtcc_pkg::RTCC_MCLR_BIT] = ctrl.clear_on_match;
			next_rdata[rtcc_pkg::RTCC_PRESC_LSB +: 4] = ctrl.prescaler;
		end else if (hit_status) begin
			next_rdata[rtcc_pkg::RTCC_PEND_BIT]   = sync_pending;
			next_rdata[rtcc_pkg::RTCC_ACTIVE_BIT] = active;
		end
	end

	// APB answer: one access cycle, no wait states
	// Read data captured at setup, so it stands through the access cycle
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pready  <= 1'b0;
			prdata  <= rtcc_pkg::RTCC_RDATA_IDLE;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup;
			pslverr <= setup & ~(hit_ctrl | hit_status);
			if (setup && !pwrite) begin
				prdata <= next_rdata;
			end else if (setup) begin
				prdata <= rtcc_pkg::RTCC_RDATA_IDLE;
			end
		end
	end

endmodule

// ==== tb/rtcc_ctrl_checker.sv ====
// Port assertions for the counter control block.
// Assumes one clock domain and asynchronous active-high reset.
`timescale 1ns/1ps
module rtcc_ctrl_checker (
	// Clock and reset
	input wire logic                 ref_clk,
	input wire logic                 rst,
	// APB slave side
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pwrite,
	input wire logic [11:0]          paddr,
	input wire logic                 pready,
	input wire logic [31:0]          prdata,
	input wire logic                 pslverr,
	// Counter controls
	input wire rtcc_pkg::rtcc_cnt_s  cnt_ctl
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Bus timing and decode
	ready_one_a: assert property (psel && !penable |=> pready)
		else $error("pready late after setup");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held too long");
	ready_idle_a: assert property (!psel |=> !pready)
		else $error("pready without select");
	unmapped_err_a: assert property (psel && !penable
		&& paddr != rtcc_pkg::RTCC_CTRL_OFF
		&& paddr != rtcc_pkg::RTCC_STATUS_OFF |=> pslverr)
		else $error("unmapped address accepted");
	err_data_a: assert property (pslverr |-> pready && prdata == 0)
		else $error("error answer malformed");
	// Register layout
	read_width_a: assert property (
		pready && !pwrite |-> prdata[31:16] == 16'h0000)
		else $error("upper read bits set");
	ctrl_resv_a: assert property (pready && !pwrite
		&& paddr == rtcc_pkg::RTCC_CTRL_OFF
		|-> prdata[15:12] == 4'h0 && prdata[5:4] == 2'h0)
		else $error("reserved control bits set");
	// Counter controls
	hour_mode_a: assert property (
		cnt_ctl.hour_12h |-> cnt_ctl.mode == rtcc_pkg::RTCC_MODE_CLOCK)
		else $error("12-hour outside clock mode");
	match_mode_a: assert property (
		cnt_ctl.counter_clear && !cnt_ctl.soft_reset |->
		cnt_ctl.mode inside {rtcc_pkg::RTCC_MODE_CNT32,
		rtcc_pkg::RTCC_MODE_CLOCK})
		else $error("match clear in wrong mode");
	reset_off_a: assert property (cnt_ctl.soft_reset
		|-> cnt_ctl.counter_clear ##1 !cnt_ctl.running)
		else $error("soft reset left counter on");
	c_srst: cover property (cnt_ctl.soft_reset);
	c_hour: cover property (cnt_ctl.hour_12h);
	c_clr: cover property (cnt_ctl.counter_clear && !cnt_ctl.soft_reset);
	c_err: cover property (pslverr);
endmodule

// ==== tb/rtc_control_register_tb_top.sv ====
// Self-checking bench for the counter control block.
// Assumes the block answers APB with one access cycle.
`timescale 1ns/1ps
module rtc_control_register_tb_top;
	localparam logic [11:0] CA = rtcc_pkg::RTCC_CTRL_OFF;
	localparam logic [11:0] SA = rtcc_pkg::RTCC_STATUS_OFF;
	logic                ref_clk = 0;
	logic                rst = 1;
	logic                psel = 0;
	logic                penable = 0;
	logic                pwrite = 0;
	logic [11:0]         paddr = 0;
	logic [31:0]         pwdata = 0;
	logic [3:0]          pstrb = 4'hF;
	logic                rtc_source_clock = 0;
	logic                compare_match = 0;
	logic                src_run = 1;
	logic [2:0]          sdiv = 0;
	logic                pready, pslverr, err;
	logic [31:0]         prdata, rd;
	rtcc_pkg::rtcc_cnt_s cnt_ctl;
	int                  num_errors = 0;
	int                  cmp_count = 0;
	int                  srst_seen = 0;
	// Clock and slow source clock, ten cycles a period
	always #2 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		if (src_run) begin
			sdiv <= (sdiv == 3'h4) ? 3'h0 : sdiv + 3'h1;
			if (sdiv == 3'h4)
				rtc_source_clock <= ~rtc_source_clock;
		end
	end
	// Count soft reset pulses handed to the counter
	always @(posedge ref_clk) begin
		if (cnt_ctl.soft_reset === 1'b1)
			srst_seen++;
	end
	rtcc_ctrl dut (.ref_clk(ref_clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .pready(pready),
		.prdata(prdata), .pslverr(pslverr),
		.rtc_source_clock(rtc_source_clock),
		.compare_match(compare_match), .cnt_ctl(cnt_ctl));
	// Verdict and stop
	task automatic end_of_test();
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic hang();
		num_errors++;
		$display("[ERR] %0t wait ran out", $time);
		end_of_test();
	endtask
	// One APB transfer; result kept in rd and err
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [15:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0000, d};
		@(posedge ref_clk);
		penable <= 1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 8);
		if (n == 8)
			hang();
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic rdc(input logic [11:0] a, input logic [15:0] e);
		xfer(0, a, 16'h0000);
		chk(rd[15:0], e);
	endtask
	task automatic wait_idle();
		int n;
		for (n = 0; n < 100; n++) begin
			xfer(0, SA, 16'h0000);
			if (rd[0] === 1'b0)
				break;
		end
		if (n == 100)
			hang();
	endtask
	// Reset values and an unmapped read
	task automatic t_reset();
		rdc(CA, 16'h0000);
		rdc(SA, 16'h0000);
		xfer(0, 12'h008, 16'h0000);
		chk({15'h0000, err}, 16'h0001);
	endtask
	// Configure, enable, lock, match clear, disable
	task automatic t_cfg();
		logic hit;
		xfer(1, CA, 16'h02C8);
		rdc(CA, 16'h02C8);
		rdc(SA, 16'h0000);
		src_run <= 0;
		xfer(1, CA, 16'h02CA);
		rdc(SA, 16'h0001);
		rdc(CA, 16'h02CA);
		src_run <= 1;
		wait_idle();
		rdc(SA, 16'h0002);
		chk({15'h0000, cnt_ctl.running}, 16'h0001);
		xfer(1, CA, 16'h0002);
		rdc(CA, 16'h02CA);
		chk({15'h0000, cnt_ctl.hour_12h}, 16'h0001);
		compare_match <= 1;
		@(posedge ref_clk);
		compare_match <= 0;
		hit = 0;
		repeat (4) begin
			@(posedge ref_clk);
			hit |= cnt_ctl.counter_clear;
		end
		chk({15'h0000, hit}, 16'h0001);
		xfer(1, CA, 16'h02C8);
		rdc(CA, 16'h02C8);
		wait_idle();
		rdc(SA, 16'h0000);
	endtask
	// Soft reset beats the rest of its write
	task automatic t_soft_reset_request();
		xfer(1, CA, 16'h02C8);
		rdc(SA, 16'h0000);
		rdc(CA, 16'h02C8);
		chk(16'(srst_seen), 16'h0000);
		src_run <= 0;
		xfer(1, CA, 16'h0A0F);
		rdc(CA, 16'h0001);
		rdc(SA, 16'h0001);
		src_run <= 1;
		wait_idle();
		rdc(CA, 16'h0000);
		chk({14'h0000, cnt_ctl.mode}, 16'h0000);
		chk(16'(srst_seen), 16'h0001);
		chk({15'h0000, cnt_ctl.running}, 16'h0000);
	endtask
	// The three non-reserved modes with 12-hour format requested
	task automatic t_modes();
		for (int m = 0; m < 3; m++) begin
			xfer(1, CA, 16'(16'h0040 | (m << 2)));
			rdc(CA, 16'(16'h0040 | (m << 2)));
			chk({14'h0000, cnt_ctl.mode}, 16'(m));
			chk({15'h0000, cnt_ctl.hour_12h}, 16'(m == 2));
		end
	endtask
	// Tick spacing for several prescaler codes
	task automatic t_presc();
		int cs[4] = '{0, 1, 4, 10};
		int n, t, g;
		foreach (cs[i]) begin
			xfer(1, CA, 16'(cs[i] << 8));
			xfer(1, CA, 16'((cs[i] << 8) | 2));
			wait_idle();
			n = 0;
			t = 0;
			g = 0;
			while (t < 2) begin
				@(posedge ref_clk);
				g++;
				if (t > 0)
					n++;
				if (cnt_ctl.counter_tick === 1'b1)
					t++;
				if (g > 30000)
					hang();
			end
			chk(16'(n), 16'(10 << cs[i]));
			xfer(1, CA, 16'(cs[i] << 8));
			wait_idle();
		end
	endtask
	initial begin
		repeat (2) @(posedge ref_clk);
		rst <= 0;
		t_reset();
		t_cfg();
		t_soft_reset_request();
		t_modes();
		t_presc();
		end_of_test();
	end
endmodule
bind rtcc_ctrl rtcc_ctrl_checker u_chk (.ref_clk(ref_clk), .rst(rst),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pready(pready), .prdata(prdata), .pslverr(pslverr),
	.cnt_ctl(cnt_ctl));
